// >>> design/vsr_pkg.sv
`default_nettype none

// ****************************************************************
// Constants of the serial control slave.
// ****************************************************************
package vsr_pkg;

  // Reference clock period and the timing figures derived from it.
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SPIKE_NS      = 32;
  // Spikes of this many samples or fewer are rejected.
  localparam int unsigned SPIKE_CYC     = SPIKE_NS / CLK_PERIOD_NS;
  // Longest output slew, used as the protection suspend window.
  localparam int unsigned SETTLE_US     = 20;
  localparam int unsigned SETTLE_CYC    = SETTLE_US * 1000 / CLK_PERIOD_NS;

  // Register addresses as carried by the pointer byte.
  localparam logic [7:0] REG_LEVEL_ADDR = 8'h00;
  localparam logic [7:0] REG_CTRL_ADDR  = 8'h01;

  // Reset values: code 0110010 with its parity bit, control 1001.
  localparam logic [7:0] LEVEL_RST = 8'h32;
  localparam logic [7:0] CTRL_RST  = 8'h09;

  // Field positions.
  localparam int unsigned PARITY_BIT        = 7;
  localparam int unsigned CTRL_INTERNAL_BIT = 7;
  localparam int unsigned CTRL_PROT_CHG_BIT = 4;
  localparam int unsigned CTRL_LIGHT_BIT    = 3;
  localparam int unsigned CTRL_PROT_MODE_BIT = 0;
  // Implemented control bits; the others read as zero.
  localparam logic [7:0] CTRL_MASK = 8'h99;

  // Upper six bits of the slave address; the select pin fills bit 0.
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h1b;
  localparam logic [3:0] BYTE_BITS     = 4'h8;

  // Protocol states, one-hot.
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_ADDR  = 5'b00010,
    ST_PTR   = 5'b00100,
    ST_WDATA = 5'b01000,
    ST_RDATA = 5'b10000
  } vsr_state_e;

endpackage

`default_nettype wire

// >>> design/vsr_serial_regs.sv
`timescale 1ns/10ps
`default_nettype none

module vsr_serial_regs #(
  parameter int unsigned SUSPEND_CYC = vsr_pkg::SETTLE_CYC
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic       i_address_select_pin,
  input  wire logic [6:0] i_ext_level_code,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  output logic [6:0]      o_output_level_code,
  output logic            o_internal_select,
  output logic            o_protection_suspend,
  output logic            o_light_load_pulse_select,
  output logic            o_protection_latch_off
);
  import vsr_pkg::*;

  localparam int unsigned SW = $clog2(SUSPEND_CYC + 1);

  // ****************************************************************
  // Pin synchronisers and spike filters.
  // ****************************************************************
  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic [1:0] filt_r;
  logic [1:0] filt_d_r;
  logic [3:0] flt_cnt_r [2];
  logic       sel_meta_r;
  logic       sel_sync_r;
  logic [6:0] ext_meta_r;
  logic [6:0] ext_sync_r;
  logic [6:0] ext_prev_r;

  // Two flops per pin, plus a third holding the previous external code sample; the first is read only by the second.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      meta_r     <= 2'h3;
      sync_r     <= 2'h3;
      sel_meta_r <= 1'b0;
      sel_sync_r <= 1'b0;
      ext_meta_r <= 7'h00;
      ext_sync_r <= 7'h00;
      ext_prev_r <= 7'h00;
    end else begin
      meta_r     <= {i_sda, i_scl};
      sync_r     <= meta_r;
      sel_meta_r <= i_address_select_pin;
      sel_sync_r <= sel_meta_r;
      ext_meta_r <= i_ext_level_code;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
    end
  end

  // A line only changes after it differs for more than the spike width.
  // This adds about 40 ns of latency, far inside the 400 kHz bit time.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      filt_r   <= 2'h3;
      filt_d_r <= 2'h3;
      for (int i = 0; i < 2; i++) begin
        flt_cnt_r[i] <= 4'h0;
      end
    end else begin
      filt_d_r <= filt_r;
      for (int i = 0; i < 2; i++) begin
        if (sync_r[i] == filt_r[i]) begin
          flt_cnt_r[i] <= 4'h0;
        end else if (flt_cnt_r[i] == 4'(SPIKE_CYC)) begin
          filt_r[i]    <= sync_r[i];
          flt_cnt_r[i] <= 4'h0;
        end else begin
          flt_cnt_r[i] <= flt_cnt_r[i] + 4'h1;
        end
      end
    end
  end

  // ****************************************************************
  // Bus events.
  // ****************************************************************
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  // Edges are found on the filtered lines at any rate up to 400 kHz.
  assign scl_rise = filt_r[0] & ~filt_d_r[0];
  assign scl_fall = ~filt_r[0] & filt_d_r[0];
  assign start_ev = filt_r[0] & filt_d_r[0] & ~filt_r[1] & filt_d_r[1];
  assign stop_ev  = filt_r[0] & filt_d_r[0] & filt_r[1] & ~filt_d_r[1];

  // ****************************************************************
  // Byte decode.
  // ****************************************************************
  vsr_state_e state_r;
  logic [3:0] bitcnt_r;
  logic       ack_slot_r;
  logic       sda_oe_r;
  logic       rw_r;
  logic       ptr_r;
  logic       mnack_r;
  logic [7:0] shreg_r;
  logic [7:0] tx_r;
  logic [7:0] lvl_r;
  logic [7:0] ctrl_r;
  logic       addr_hit;
  logic       parity_ok;
  logic       ptr_ok;
  logic       byte_end;
  logic       commit;
  logic [7:0] rd_byte;
  logic [2:0] tx_idx;

  assign addr_hit  = shreg_r[7:1] == {SLAVE_ADDR_HI, sel_sync_r};
  // The check relies on the master setting bit 7 as the XNOR.
  assign parity_ok = shreg_r[PARITY_BIT] == ~^shreg_r[6:0];
  assign ptr_ok    = (shreg_r == REG_LEVEL_ADDR) ||
                     (shreg_r == REG_CTRL_ADDR);
  assign byte_end  = scl_fall && !ack_slot_r && bitcnt_r == BYTE_BITS;
  assign commit    = byte_end && state_r == ST_WDATA && parity_ok;
  assign rd_byte   = ptr_r ? ctrl_r : lvl_r;
  assign tx_idx    = 3'(4'h7 - bitcnt_r);

  // Incoming bits are shifted in on each rising clock of a byte.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      shreg_r <= 8'h00;
    end else if (scl_rise && !ack_slot_r && bitcnt_r != BYTE_BITS) begin
      shreg_r <= {shreg_r[6:0], filt_r[1]};
    end
  end

  // ****************************************************************
  // Protocol state machine.
  // ****************************************************************
  // Start and stop win over clock edges, so a repeated start always
  // restarts the address check.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_r    <= ST_IDLE;
      bitcnt_r   <= 4'h0;
      ack_slot_r <= 1'b0;
      sda_oe_r   <= 1'b0;
      rw_r       <= 1'b0;
      ptr_r      <= 1'b0;
      mnack_r    <= 1'b0;
      tx_r       <= 8'h00;
    end else if (start_ev) begin
      state_r    <= ST_ADDR;
      bitcnt_r   <= 4'h0;
      ack_slot_r <= 1'b0;
      sda_oe_r   <= 1'b0;
    end else if (stop_ev) begin
      state_r    <= ST_IDLE;
      bitcnt_r   <= 4'h0;
      ack_slot_r <= 1'b0;
      sda_oe_r   <= 1'b0;
    end else if (state_r != ST_IDLE) begin
      if (scl_rise) begin
        if (ack_slot_r) begin
          mnack_r <= filt_r[1];
        end else if (bitcnt_r != BYTE_BITS) begin
          bitcnt_r <= bitcnt_r + 4'h1;
        end
      end else if (byte_end) begin
        ack_slot_r <= 1'b1;
        unique case (state_r)
          ST_ADDR: begin
            if (addr_hit) begin
              sda_oe_r <= 1'b1;
              rw_r     <= shreg_r[0];
            end else begin
              state_r <= ST_IDLE;
            end
          end
          ST_PTR: begin
            if (ptr_ok) begin
              sda_oe_r <= 1'b1;
              ptr_r    <= shreg_r[0];
            end else begin
              state_r <= ST_IDLE;
            end
          end
          ST_WDATA: begin
            sda_oe_r <= parity_ok;
          end
          ST_RDATA: begin
            sda_oe_r <= 1'b0;
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end else if (scl_fall && ack_slot_r) begin
        ack_slot_r <= 1'b0;
        bitcnt_r   <= 4'h0;
        sda_oe_r   <= 1'b0;
        unique case (state_r)
          ST_ADDR: begin
            if (rw_r) begin
              state_r  <= ST_RDATA;
              tx_r     <= rd_byte;
              sda_oe_r <= ~rd_byte[7];
            end else begin
              state_r <= ST_PTR;
            end
          end
          ST_PTR: begin
            state_r <= ST_WDATA;
          end
          ST_WDATA: begin
            // Further bytes go to the same register, so a refused byte
            // can simply be sent again.
            state_r <= ST_WDATA;
          end
          ST_RDATA: begin
            if (mnack_r) begin
              state_r <= ST_IDLE;
            end else begin
              tx_r     <= rd_byte;
              sda_oe_r <= ~rd_byte[7];
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end else if (scl_fall && state_r == ST_RDATA) begin
        sda_oe_r <= ~tx_r[tx_idx];
      end
    end
  end

  // ****************************************************************
  // Registers and outputs.
  // ****************************************************************
  logic [6:0]    act_r;
  logic [SW-1:0] susp_cnt_r;
  logic          susp_r;

  // Written at the fall of the eighth data clock, clock 26 of the
  // transfer, so the new value acts before clock 27 ends.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      lvl_r  <= LEVEL_RST;
      ctrl_r <= CTRL_RST;
    end else if (commit) begin
      if (!ptr_r) begin
        lvl_r <= shreg_r;
      end else begin
        ctrl_r <= shreg_r & CTRL_MASK;
      end
    end
  end

  // External words are taken once two samples agree, so bit skew shorter than one clock cycle never shows.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      act_r <= 7'h00;
    end else if (ctrl_r[CTRL_INTERNAL_BIT]) begin
      act_r <= lvl_r[6:0];
    end else if (ext_sync_r == ext_prev_r) begin
      act_r <= ext_sync_r;
    end
  end

  // Protection is held off for one full output slew after a new code.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      susp_cnt_r <= '0;
      susp_r     <= 1'b0;
    end else if (commit && !ptr_r && ctrl_r[CTRL_PROT_CHG_BIT]) begin
      susp_cnt_r <= SW'(SUSPEND_CYC);
      susp_r     <= 1'b1;
    end else if (susp_cnt_r != '0) begin
      susp_cnt_r <= susp_cnt_r - SW'(1);
      susp_r     <= susp_cnt_r != SW'(1);
    end
  end

  assign o_sda_out                 = 1'b0;
  assign o_sda_oe                  = sda_oe_r;
  assign o_output_level_code       = act_r;
  assign o_internal_select         = ctrl_r[CTRL_INTERNAL_BIT];
  assign o_protection_suspend      = susp_r;
  assign o_light_load_pulse_select = ctrl_r[CTRL_LIGHT_BIT];
  assign o_protection_latch_off    = ctrl_r[CTRL_PROT_MODE_BIT];

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  rst_values_a: assert property (
    $past(i_rst) |-> lvl_r == LEVEL_RST && ctrl_r == CTRL_RST)
    else $error("Registers not at reset values.");

  parity_guard_a: assert property (
    !$past(i_rst) && lvl_r != $past(lvl_r)
      |-> lvl_r[7] == ~^lvl_r[6:0] && $past(state_r) == ST_WDATA)
    else $error("Voltage register took a bad-parity byte.");

  addr_ack_a: assert property (
    byte_end && state_r == ST_ADDR && addr_hit && !start_ev && !stop_ev
      |=> sda_oe_r ##1 sda_oe_r)
    else $error("Matching address not acknowledged.");

  addr_miss_a: assert property (
    byte_end && state_r == ST_ADDR && !addr_hit && !start_ev && !stop_ev
      |=> state_r == ST_IDLE && !sda_oe_r)
    else $error("Mismatched address not ignored.");

  dir_read_a: assert property (
    scl_fall && ack_slot_r && state_r == ST_ADDR && rw_r
      && !start_ev && !stop_ev |=> state_r == ST_RDATA)
    else $error("Read direction not taken.");

  data_nack_a: assert property (
    byte_end && state_r == ST_WDATA && !parity_ok && !start_ev && !stop_ev
      |=> !sda_oe_r && lvl_r == $past(lvl_r) && ctrl_r == $past(ctrl_r))
    else $error("Bad data byte acknowledged or stored.");
  read_bit_a: assert property (
    scl_fall && !ack_slot_r && state_r == ST_RDATA && bitcnt_r != BYTE_BITS
      && bitcnt_r != 4'h0 && !start_ev && !stop_ev
      |=> sda_oe_r == ~tx_r[3'(4'h7 - $past(bitcnt_r))])
    else $error("Read bit driven wrongly.");
  spike_reject_a: assert property (
    $rose(filt_r[0]) |-> $past(sync_r[0], 1) && $past(sync_r[0], 9))
    else $error("Clock line passed a short spike.");
  suspend_a: assert property (
    commit && !ptr_r && ctrl_r[CTRL_PROT_CHG_BIT] |=> o_protection_suspend)
    else $error("Protection not suspended on code change.");
  internal_sel_a: assert property (
    (ctrl_r[CTRL_INTERNAL_BIT] && $stable(lvl_r)) [*2]
      |=> o_output_level_code == $past(lvl_r[6:0]))
    else $error("Internal mode does not follow register code.");

endmodule // vsr_serial_regs

`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Bench for the serial control slave.
// ****************************************************************
module tb_top;
  localparam int unsigned SUSP = 16;
  logic       clk, rst, sel, m_scl, m_sda, sda_out, sda_oe;
  logic       int_sel, susp, light, latch;
  logic [6:0] ext, level;
  wire logic  sda_line;
  int         fail_count = 0;
  int         compares = 0;
  int         run = 0;
  int         susp_len = 0;
  int         susp_n = 0;

  // Open-drain line: low while either party pulls, else the pull-up.
  assign sda_line = m_sda & (sda_oe ? sda_out : 1'b1);

  vsr_serial_regs #(.SUSPEND_CYC(SUSP)) DUT (
    .i_ref_clk(clk), .i_rst(rst), .i_scl(m_scl), .i_sda(sda_line),
    .i_address_select_pin(sel), .i_ext_level_code(ext),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_output_level_code(level),
    .o_internal_select(int_sel), .o_protection_suspend(susp),
    .o_light_load_pulse_select(light), .o_protection_latch_off(latch)
  );

  vsr_bus_master M (
    .i_ref_clk(clk), .i_sda_line(sda_line), .o_scl(m_scl), .o_sda(m_sda)
  );

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] addr(input logic rw);
    return 8'h6c | {6'h00, sel, rw};
  endfunction

  task automatic open_frame(input logic [7:0] ptr, input logic exp);
    logic a;
    M.start();
    M.put_byte(addr(1'b0), a);
    check("addr ack", a, 1'b1);
    M.put_byte(ptr, a);
    check("ptr ack", a, exp);
  endtask

  // Data bytes carry bit 7 as the XNOR of bits 6..0 unless a bad one.
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d,
                    input logic exp);
    logic a;
    open_frame(ptr, 1'b1);
    M.put_byte(d, a);
    check("data ack", a, exp);
    M.stop();
  endtask

  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    logic       a;
    logic [7:0] d;
    open_frame(ptr, 1'b1);
    M.stop();
    M.start();
    M.put_byte(addr(1'b1), a);
    check("read ack", a, 1'b1);
    M.get_byte(1'b0, d);
    check("read byte", d, exp);
    M.get_byte(1'b1, d);
    check("again byte", d, exp);
    M.stop();
  endtask

  task automatic t_reset();
    check("internal", int_sel, 1'b0);
    check("light", light, 1'b1);
    check("latch", latch, 1'b1);
    check("suspend", susp, 1'b0);
    check("level", level, ext);
    rd(8'h00, 8'h32);
    rd(8'h01, 8'h09);
  endtask

  task automatic t_address();
    logic a;
    for (int s = 0; s < 2; s++) begin
      sel <= s[0];
      repeat (20) @(posedge clk);
      for (int k = 0; k < 2; k++) begin
        M.start();
        M.put_byte(8'h6c | {6'h00, k[0], 1'b0}, a);
        check("select ack", a, s == k);
        M.put_byte(8'h00, a);
        check("ignored ack", a, s == k);
        M.stop();
      end
    end
    sel <= 1'b0;
    repeat (20) @(posedge clk);
    open_frame(8'h02, 1'b0);
    M.stop();
    M.start();
    M.glitch();
    M.put_byte(addr(1'b0), a);
    check("spike ack", a, 1'b1);
    M.stop();
  endtask

  task automatic t_voltage();
    wr(8'h00, 8'h91, 1'b1);
    wr(8'h00, 8'h11, 1'b0);
    rd(8'h00, 8'h91);
    wr(8'h00, 8'h45, 1'b1);
    rd(8'h00, 8'h45);
    check("level ext", level, ext);
  endtask

  task automatic t_control();
    logic a;
    int   n0;
    wr(8'h01, 8'h98, 1'b1);
    rd(8'h01, 8'h98);
    check("internal", int_sel, 1'b1);
    check("light", light, 1'b1);
    check("latch", latch, 1'b0);
    check("level int", level, 7'h45);
    wr(8'h01, 8'h99, 1'b0);
    rd(8'h01, 8'h98);
    n0 = susp_n;
    open_frame(8'h00, 1'b1);
    M.put_byte(8'hab, a);
    check("data ack", a, 1'b1);
    check("level soon", level, 7'h2b);
    M.stop();
    check("suspend count", susp_n - n0, 1);
    check("suspend len", susp_len, SUSP);
    wr(8'h01, 8'h02, 1'b1);
    rd(8'h01, 8'h00);
    check("internal", int_sel, 1'b0);
    check("light", light, 1'b0);
    check("latch", latch, 1'b0);
    n0 = susp_n;
    wr(8'h00, 8'h91, 1'b1);
    check("no suspend", susp_n - n0, 0);
    ext <= 7'h15;
    repeat (10) @(posedge clk);
    check("level ext", level, 7'h15);
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Measures each suspend pulse so its length can be judged later.
  always @(posedge clk) begin
    if (susp === 1'b1) begin
      run = run + 1;
    end else if (run != 0) begin
      susp_len = run;
      susp_n = susp_n + 1;
      run = 0;
    end
  end

  // Reference clock of 4 ns.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // A hang is cut short well past the expected run length.
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    sel = 1'b0;
    ext = 7'h2a;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (24) @(posedge clk);
    t_reset();
    t_address();
    t_voltage();
    t_control();
    print_verdict();
  end
endmodule // tb_top

`default_nettype wire

// >>> tb/vsr_bus_master.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Serial bus master model with an 80 ns link clock.
// ****************************************************************
module vsr_bus_master (
  input  wire logic i_ref_clk,
  input  wire logic i_sda_line,
  output var  logic o_scl,
  output var  logic o_sda
);
  localparam int HALF = 10;

  // Both lines start released, so the pull-ups hold them high.
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  // Data moves mid low phase and is sampled late in the high phase,
  // because the slave answers some twelve cycles after the clock falls.
  task automatic bit_io(input logic b, input int pre, output logic s);
    tick(HALF / 2 + pre);
    o_sda <= b;
    tick(HALF / 2);
    o_scl <= 1'b1;
    tick(HALF);
    s = i_sda_line;
    o_scl <= 1'b0;
  endtask

  task automatic start();
    tick(HALF);
    o_sda <= 1'b0;
    tick(HALF);
    o_scl <= 1'b0;
  endtask

  task automatic stop();
    tick(HALF / 2);
    o_sda <= 1'b0;
    tick(HALF / 2);
    o_scl <= 1'b1;
    tick(HALF);
    o_sda <= 1'b1;
    tick(2 * HALF);
  endtask

  // A bit that the slave answers, or that follows its answer, gets a
  // longer low phase: the slave's own filter sees its answer about 23
  // cycles after the fall, and must see it before the clock rises.
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], (i == 7) ? 8 : 0, s);
    bit_io(1'b1, 8, s);
    ack = ~s;
  endtask

  task automatic get_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, 8, s);
      d[i] = s;
    end
    bit_io(mack, 8, s);
  endtask

  // A clock spike of 32 ns that must not count as a bit.
  task automatic glitch();
    tick(HALF);
    o_scl <= 1'b1;
    tick(8);
    o_scl <= 1'b0;
  endtask
endmodule // vsr_bus_master

`default_nettype wire
